/* core/lvds_rx_sync_pkg.sv */
package lvds_rx_sync_pkg;
   // ------------------------------------------------------------
   // Phase synchronizer geometry
   // ------------------------------------------------------------
   localparam int SYNC_DEPTH = 6;
   localparam int PTR_W = 3;
   localparam logic [2:0] PTR_LAST = 3'h5;
   localparam logic [2:0] WR_PTR_RST = 3'h0;
   localparam logic [2:0] RD_PTR_RST = 3'h0;
   // Core side holds the synchronizer reset request at least this many cycles
   localparam logic [1:0] RST_HOLD_CYCLES = 2'h3;

   // ------------------------------------------------------------
   // Clocking and word layout
   // ------------------------------------------------------------
   localparam int MULT_FACTOR = 10;
   localparam int WORD_W = 8;
   localparam logic [2:0] WORD_LAST = 3'h7;
   localparam logic [3:0] FACTOR_A_RST = 4'h8;
   localparam logic [3:0] FACTOR_B_RST = 4'ha;
   localparam logic CLK_SEL_RST = 1'b0;
   localparam int BUF_DEPTH = 8;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0] factor_a;
      logic [3:0] factor_b;
      logic clk_sel;
   } pll_cfg_t;

   localparam pll_cfg_t PLL_CFG_RST = '{FACTOR_A_RST, FACTOR_B_RST, CLK_SEL_RST};
endpackage

/* core/lvds_rx_phase_sync_fifo.sv */
`timescale 1ns/1ns

// ------------------------------------------------------------
// Word buffer between deserializer and core
// ------------------------------------------------------------
module sync_word_buffer #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic out_valid;
      logic [W-1:0] out_data;
   } buf_t;

   buf_t q, d;
   logic [W-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // Handshakes on both sides
   assign push = i_in_valid && (q.count != (AW+1)'(DEPTH));
   assign pop = (q.count != '0) && (!q.out_valid || i_out_ready);
   assign o_in_ready = (q.count != (AW+1)'(DEPTH));
   assign o_out_valid = q.out_valid;
   assign o_out_data = q.out_data;

   // Next state of pointers and output stage
   always_comb begin
      d = q;
      if (push) begin
         d.wptr = (q.wptr == AW'(DEPTH-1)) ? '0 : AW'(q.wptr + 1'b1);
      end
      if (pop) begin
         d.rptr = (q.rptr == AW'(DEPTH-1)) ? '0 : AW'(q.rptr + 1'b1);
         d.out_data = mem[q.rptr];
         d.out_valid = 1'b1;
      end else if (i_out_ready) begin
         d.out_valid = 1'b0;
      end
      d.count = (AW+1)'(q.count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Storage array
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[q.wptr] <= i_in_data;
      end
   end
endmodule

// ------------------------------------------------------------
// Receive phase synchronizer, deserializer and clock strobes
// ------------------------------------------------------------
module lvds_rx_phase_sync_fifo #(
   parameter int NUM_CH = 18,
   parameter int CHAN_ID = 1
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_rec_clk,
   input wire logic i_serial_in,
   input wire logic i_fifo_rst,
   input wire logic i_soft_cdr,
   input wire logic i_lock_raw,
   input wire logic i_chan_rst,
   input wire logic i_pll_rst,
   input wire logic i_cfg_valid,
   input wire lvds_rx_sync_pkg::pll_cfg_t i_cfg,
   input wire logic i_word_ready,
   output logic o_direct_bit,
   output logic o_sync_bit,
   output logic o_sync_bit_valid,
   output logic o_locked,
   output logic o_load_a,
   output logic o_load_b,
   output lvds_rx_sync_pkg::pll_cfg_t o_cfg,
   output logic o_word_valid,
   output logic [8*NUM_CH-1:0] o_core_bus,
   output logic o_overrun
);
   localparam int BUS_W = lvds_rx_sync_pkg::WORD_W * NUM_CH;
   localparam int LANE_LSB = lvds_rx_sync_pkg::WORD_W * (CHAN_ID - 1);
   localparam int PW = lvds_rx_sync_pkg::PTR_W;

   // ------------------------------------------------------------
   // Recovered clock domain: capture and FIFO write side
   // ------------------------------------------------------------
   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic dbit;
      logic running;
      logic [PW-1:0] wptr;
      logic [lvds_rx_sync_pkg::SYNC_DEPTH-1:0] mem;
   } wr_t;

   wr_t wr_q, wr_d;
   logic cap_q;

   typedef struct packed {
      logic rst_req;
      logic [1:0] rst_cnt;
      logic run_s1;
      logic run_s2;
      logic cdr_s1;
      logic cdr_s2;
      logic lock_s1;
      logic lock_s2;
      logic locked;
      logic [PW-1:0] rptr;
      logic sbit;
      logic sbit_v;
      logic [lvds_rx_sync_pkg::WORD_W-1:0] shreg;
      logic [2:0] bitcnt;
      logic [lvds_rx_sync_pkg::WORD_W-1:0] word;
      logic push;
      logic overrun;
      logic [3:0] cnt_a;
      logic [3:0] cnt_b;
      logic load_a;
      logic load_b;
      lvds_rx_sync_pkg::pll_cfg_t cfg;
   } rd_t;

   rd_t rd_q, rd_d;
   logic buf_ready;
   logic [BUS_W-1:0] lane_word;

   // Serial bit taken on the falling edge of the recovered clock
   always_ff @(negedge i_rec_clk) begin
      cap_q <= i_serial_in;
   end

   // Write pointer walks the six-entry ring after reset release
   always_comb begin
      wr_d = wr_q;
      wr_d.rst_s1 = rd_q.rst_req;
      wr_d.rst_s2 = wr_q.rst_s1;
      wr_d.dbit = cap_q;
      if (wr_q.rst_s2) begin
         wr_d.wptr = lvds_rx_sync_pkg::WR_PTR_RST;
         wr_d.running = 1'b0;
      end else begin
         wr_d.mem[wr_q.wptr] = wr_q.dbit;
         wr_d.wptr = (wr_q.wptr == lvds_rx_sync_pkg::PTR_LAST) ? '0 : PW'(wr_q.wptr + 1'b1);
         wr_d.running = 1'b1;
      end
   end

   // Write side register; its reset arrives through its own synchronizer
   always_ff @(posedge i_rec_clk) begin
      wr_q <= wr_d;
   end

   assign o_direct_bit = wr_q.dbit;

   // ------------------------------------------------------------
   // Serial clock domain: FIFO read, deserializer, lock, strobes
   // ------------------------------------------------------------
   always_comb begin
      rd_d = rd_q;
      rd_d.run_s1 = wr_q.running;
      rd_d.run_s2 = rd_q.run_s1;
      rd_d.cdr_s1 = i_soft_cdr;
      rd_d.cdr_s2 = rd_q.cdr_s1;
      rd_d.lock_s1 = i_lock_raw;
      rd_d.lock_s2 = rd_q.lock_s1;
      rd_d.push = 1'b0;
      rd_d.load_a = 1'b0;
      rd_d.load_b = 1'b0;
      // Reset request held until the write side is seen stopped
      if (i_fifo_rst) begin
         rd_d.rst_req = 1'b1;
         rd_d.rst_cnt = lvds_rx_sync_pkg::RST_HOLD_CYCLES;
      end else if (rd_q.rst_cnt != 2'h0) begin
         rd_d.rst_cnt = 2'(rd_q.rst_cnt - 1'b1);
      end else if (!rd_q.run_s2) begin
         rd_d.rst_req = 1'b0;
      end
      // Read starts only once writes run, leaving the pointers apart
      if (rd_q.rst_req || i_fifo_rst || !rd_q.run_s2) begin
         rd_d.rptr = lvds_rx_sync_pkg::RD_PTR_RST;
         rd_d.sbit_v = 1'b0;
         rd_d.bitcnt = 3'h0;
      end else if (rd_q.cdr_s2) begin
         rd_d.sbit_v = 1'b0;
      end else begin
         // Frequency must match; only a fixed phase offset is absorbed
         rd_d.sbit = wr_q.mem[rd_q.rptr];
         rd_d.sbit_v = 1'b1;
         rd_d.rptr = (rd_q.rptr == lvds_rx_sync_pkg::PTR_LAST) ? '0 : PW'(rd_q.rptr + 1'b1);
      end
      // Deserializer collects eight bits per word
      if (rd_q.sbit_v) begin
         rd_d.shreg = {rd_q.shreg[lvds_rx_sync_pkg::WORD_W-2:0], rd_q.sbit};
         rd_d.bitcnt = 3'(rd_q.bitcnt + 1'b1);
         if (rd_q.bitcnt == lvds_rx_sync_pkg::WORD_LAST) begin
            rd_d.word = {rd_q.shreg[lvds_rx_sync_pkg::WORD_W-2:0], rd_q.sbit};
            rd_d.push = 1'b1;
         end
      end
      // Word lost when the buffer is full; flag held until i_srst
      if (rd_q.push && !buf_ready) begin
         rd_d.overrun = 1'b1;
      end
      // Sticky lock, cleared only by channel reset, PLL reset or i_srst
      if (i_chan_rst || i_pll_rst) begin
         rd_d.locked = 1'b0;
      end else if (rd_q.lock_s2) begin
         rd_d.locked = 1'b1;
      end
      // Factors and clock select may change at any time
      if (i_cfg_valid) begin
         rd_d.cfg = i_cfg;
         rd_d.cnt_a = 4'h0;
         rd_d.cnt_b = 4'h0;
      end else begin
         // One serial rate, two parallel strobes
         if (rd_q.cnt_a >= 4'(rd_q.cfg.factor_a - 1'b1)) begin
            rd_d.cnt_a = 4'h0;
            rd_d.load_a = 1'b1;
         end else begin
            rd_d.cnt_a = 4'(rd_q.cnt_a + 1'b1);
         end
         if (rd_q.cnt_b >= 4'(rd_q.cfg.factor_b - 1'b1)) begin
            rd_d.cnt_b = 4'h0;
            rd_d.load_b = 1'b1;
         end else begin
            rd_d.cnt_b = 4'(rd_q.cnt_b + 1'b1);
         end
      end
   end

   // Read side register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rd_q <= '0;
         rd_q.rst_req <= 1'b1;
         rd_q.rst_cnt <= lvds_rx_sync_pkg::RST_HOLD_CYCLES;
         rd_q.cfg <= lvds_rx_sync_pkg::PLL_CFG_RST;
      end else begin
         rd_q <= rd_d;
      end
   end

   // Word placed in its channel lane of the core bus
   assign lane_word = BUS_W'(rd_q.word) << LANE_LSB;

   sync_word_buffer #(
      .W(BUS_W),
      .DEPTH(lvds_rx_sync_pkg::BUF_DEPTH)
   ) u_buf (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_in_valid(rd_q.push),
      .o_in_ready(buf_ready),
      .i_in_data(lane_word),
      .o_out_valid(o_word_valid),
      .i_out_ready(i_word_ready),
      .o_out_data(o_core_bus)
   );

   assign o_sync_bit = rd_q.sbit;
   assign o_sync_bit_valid = rd_q.sbit_v;
   assign o_locked = rd_q.locked;
   assign o_load_a = rd_q.load_a;
   assign o_load_b = rd_q.load_b;
   assign o_cfg = rd_q.cfg;
   assign o_overrun = rd_q.overrun;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   AST_RPTR_RANGE: assert property (@(posedge i_clk) disable iff (i_srst)
      rd_q.rptr <= lvds_rx_sync_pkg::PTR_LAST)
      else $error("read pointer out of range");
   AST_WPTR_STEP: assert property (@(posedge i_rec_clk) disable iff (wr_q.rst_s2)
      wr_q.running |=> wr_q.wptr == (($past(wr_q.wptr) == 3'h5) ? 3'h0 : $past(wr_q.wptr) + 3'h1))
      else $error("write pointer did not advance");
   AST_FIFO_RST: assert property (@(posedge i_clk) disable iff (i_srst)
      i_fifo_rst |=> !o_sync_bit_valid [*3])
      else $error("bit valid during synchronizer reset");
   AST_LOAD_A: assert property (@(posedge i_clk) disable iff (i_srst)
      o_load_a && o_cfg.factor_a > 4'h1 && !i_cfg_valid |=> !o_load_a)
      else $error("strobe a too close");
   AST_CFG: assert property (@(posedge i_clk) disable iff (i_srst)
      i_cfg_valid |=> o_cfg == $past(i_cfg) && !o_load_a && !o_load_b)
      else $error("reconfiguration not applied");
   AST_CAPTURE: assert property (@(posedge i_rec_clk)
      wr_q.running |=> o_direct_bit == $past(cap_q))
      else $error("captured bit not forwarded");
   AST_LANE: assert property (@(posedge i_clk) disable iff (i_srst)
      o_word_valid |-> (o_core_bus & ~(BUS_W'(8'hff) << LANE_LSB)) == '0)
      else $error("word outside its lane");
   AST_LOCK_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
      o_locked && !i_chan_rst && !i_pll_rst |=> o_locked)
      else $error("lock dropped without reset");
   AST_LOCK_CLR: assert property (@(posedge i_clk) disable iff (i_srst)
      i_chan_rst || i_pll_rst |=> !o_locked)
      else $error("lock survived reset");
   AST_BYPASS: assert property (@(posedge i_clk) disable iff (i_srst)
      rd_q.cdr_s2 |=> !o_sync_bit_valid)
      else $error("synchronizer used in bypass");
   AST_WR_RST: assert property (@(posedge i_rec_clk)
      wr_q.rst_s2 |=> wr_q.wptr == 3'h0 && !wr_q.running)
      else $error("write pointer not reset");

   COV_LOCK: cover property (@(posedge i_clk) disable iff (i_srst) $rose(o_locked));
   COV_WORD: cover property (@(posedge i_clk) disable iff (i_srst) o_word_valid && i_word_ready);
   COV_OVERRUN: cover property (@(posedge i_clk) disable iff (i_srst) $rose(o_overrun));
   COV_BYPASS: cover property (@(posedge i_clk) disable iff (i_srst) rd_q.cdr_s2 ##1 !rd_q.cdr_s2);
endmodule

/* verif/serial_tx_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Remote serial transmitter model
// ------------------------------------------------------------
module serial_tx_model (
   input wire logic i_rec_clk,
   input wire logic i_en,
   output logic o_bit,
   output logic o_prev
);
   logic [7:0] pat_q = 8'hb4;
   initial o_bit = 1'b0;
   initial o_prev = 1'b0;
   // One bit per recovered clock, launched on rising edge
   always @(posedge i_rec_clk) begin
      o_prev <= o_bit;
      pat_q <= {pat_q[6:0], pat_q[7]};
      if (i_en) begin
         o_bit <= pat_q[7];
      end else begin
         o_bit <= ~o_bit; // Released line toggles, never holds
      end
   end
endmodule

/* verif/tb_lvds_rx_phase_sync_fifo.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_lvds_rx_phase_sync_fifo;
   logic i_clk, i_srst, rec_clk, ser, prev_bit, fifo_rst, soft_cdr, lock_raw;
   logic chan_rst, pll_rst, cfg_valid, word_ready, tx_en;
   logic direct_bit, sync_bit, sync_valid, locked, load_a, load_b, word_valid, overrun;
   lvds_rx_sync_pkg::pll_cfg_t cfg, act_cfg;
   logic [143:0] core_bus;
   int errors, n_tests;

   lvds_rx_phase_sync_fifo #(.NUM_CH(18), .CHAN_ID(18)) dut_u (
      .i_clk(i_clk), .i_srst(i_srst), .i_rec_clk(rec_clk), .i_serial_in(ser),
      .i_fifo_rst(fifo_rst), .i_soft_cdr(soft_cdr), .i_lock_raw(lock_raw),
      .i_chan_rst(chan_rst), .i_pll_rst(pll_rst), .i_cfg_valid(cfg_valid),
      .i_cfg(cfg), .i_word_ready(word_ready), .o_direct_bit(direct_bit),
      .o_sync_bit(sync_bit), .o_sync_bit_valid(sync_valid), .o_locked(locked),
      .o_load_a(load_a), .o_load_b(load_b), .o_cfg(act_cfg),
      .o_word_valid(word_valid), .o_core_bus(core_bus), .o_overrun(overrun));
   serial_tx_model tx_u (.i_rec_clk(rec_clk), .i_en(tx_en), .o_bit(ser), .o_prev(prev_bit));

   // Core clock and free-running link clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      rec_clk = 1'b0;
      #1;
      forever #3 rec_clk = ~rec_clk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task step;
      @(posedge i_clk);
      #1;
   endtask
   task automatic gap(input logic b, output int n);
      int k;
      k = 0;
      while ((b ? load_b : load_a) !== 1'b1 && k < 40) begin step; k++; end
      n = 0;
      do begin step; n++; end while ((b ? load_b : load_a) !== 1'b1 && n < 40);
   endtask
   task summarize;
      $display("comparisons=%0d mismatches=%0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_lock;
      int k;
      lock_raw = 1'b1;
      step; step; `CHK(locked, 1'b0)
      step; `CHK(locked, 1'b1)
      lock_raw = 1'b0;
      for (k = 0; k < 8; k++) step;
      `CHK(locked, 1'b1)
      chan_rst = 1'b1; step; chan_rst = 1'b0; `CHK(locked, 1'b0)
      lock_raw = 1'b1;
      for (k = 0; k < 4; k++) step;
      lock_raw = 1'b0;
      for (k = 0; k < 4; k++) step;
      `CHK(locked, 1'b1)
      pll_rst = 1'b1; step; pll_rst = 1'b0; `CHK(locked, 1'b0)
      $display("test lock done");
   endtask
   task t_cfg;
      int n;
      `CHK(act_cfg, lvds_rx_sync_pkg::PLL_CFG_RST)
      gap(1'b0, n); `CHK(n, 8)
      gap(1'b1, n); `CHK(n, 10)
      cfg = '{4'h3, 4'h5, 1'b1};
      cfg_valid = 1'b1; step; cfg_valid = 1'b0;
      `CHK(act_cfg, cfg)
      gap(1'b0, n); `CHK(n, 3)
      gap(1'b1, n); `CHK(n, 5)
      $display("test cfg done");
   endtask
   task t_stream;
      int k;
      logic [7:0] exp_word;
      lock_raw = 1'b1;
      for (k = 0; k < 4; k++) step;
      fifo_rst = 1'b1; step; fifo_rst = 1'b0; step;
      `CHK(sync_valid, 1'b0)
      k = 0;
      while (sync_valid !== 1'b1 && k < 60) begin step; k++; end
      `CHK(sync_valid, 1'b1)
      `CHK(locked, 1'b1)
      `CHK(act_cfg, cfg)
      // First eight bits after the synchronizer reset form one word, first bit on top
      exp_word = 8'h00;
      for (k = 0; k < 8; k++) begin
         exp_word = {exp_word[6:0], sync_bit};
         step;
      end
      word_ready = 1'b1;
      k = 0;
      while (word_valid !== 1'b1 && k < 60) begin step; k++; end
      `CHK(word_valid, 1'b1)
      `CHK(core_bus[135:0], 136'h0)
      `CHK(core_bus[143:136], exp_word)
      $display("test stream done");
   endtask
   task t_bypass;
      int k;
      soft_cdr = 1'b1;
      for (k = 0; k < 6; k++) step;
      `CHK(sync_valid, 1'b0)
      for (k = 0; k < 4; k++) begin
         @(posedge rec_clk);
         #1;
         `CHK(direct_bit, prev_bit)
      end
      step;
      soft_cdr = 1'b0;
      k = 0;
      while (sync_valid !== 1'b1 && k < 60) begin step; k++; end
      `CHK(sync_valid, 1'b1)
      $display("test bypass done");
   endtask
   task t_overrun;
      int k;
      word_ready = 1'b0;
      k = 0;
      while (overrun !== 1'b1 && k < 300) begin step; k++; end
      `CHK(overrun, 1'b1)
      `CHK(word_valid, 1'b1)
      word_ready = 1'b1;
      k = 0;
      while (word_valid !== 1'b0 && k < 40) begin step; k++; end
      `CHK(word_valid, 1'b0)
      `CHK(overrun, 1'b1)
      i_srst = 1'b1;
      step; step; step;
      `CHK(overrun, 1'b0)
      `CHK(act_cfg, lvds_rx_sync_pkg::PLL_CFG_RST)
      i_srst = 1'b0;
      $display("test overrun done");
   endtask

   // Watchdog against a hung handshake
   initial begin
      #50000;
      errors++;
      summarize;
   end

   // Main sequence
   initial begin
      errors = 0;
      n_tests = 0;
      {fifo_rst, soft_cdr, lock_raw, chan_rst, pll_rst, cfg_valid} = 6'h00;
      // Core drains words from the start so overrun only comes from the overrun test
      word_ready = 1'b1;
      tx_en = 1'b0;
      cfg = lvds_rx_sync_pkg::PLL_CFG_RST;
      i_srst = 1'b1;
      repeat (6) step;
      i_srst = 1'b0;
      tx_en = 1'b1;
      `CHK(locked, 1'b0)
      t_lock;
      t_cfg;
      t_stream;
      t_bypass;
      t_overrun;
      summarize;
   end
endmodule
